// ==== rtl/operation_status_register_group.sv ====
// Function
// - Preset sets rising filters, clears falling, masks
// - Preset values: operation 1313, questionable 1555
// - Condition bits at weights 1, 32, 256, 1024
// - Condition register read-only, live flags
// - Event register latches filtered transitions until cleared
// - Event read returns value then clears
// - Summary flag is OR of enabled events
// - Falling filter bit catches one-to-zero change
// - Rising filter bit catches zero-to-one change
// - Both filter bits catch any change
// - Neither filter bit catches nothing
// - Filter write may raise events itself
// - Filters and mask accept 0..32727, default zero
// - Regulation state recorded after holdoff delay
// - Holdoff delays overcurrent trip, not overvoltage
// - Trigger clears wait flag; continuous re-arms

`timescale 1ns/10ps
`include "status_params.svh"

module operation_status_register_group
  import status_pkg::*;
#(
  parameter logic [`REG_W-1:0] HOLDOFF_DEFAULT = `HOLDOFF_DEFAULT
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic         cmd_valid,
  input  wire cmd_t         cmd,
  output logic              rsp_valid,
  output rsp_t              rsp,
  input  wire logic         cal_busy_pin,
  input  wire reg_flags_t   regulation_pins,
  input  wire logic         overvoltage_pin,
  input  wire logic         overcurrent_enable,
  input  wire logic         output_reprogram,
  input  wire logic         trigger_initiate,
  input  wire logic         trigger_accept,
  input  wire logic         trigger_continuous,
  output logic              operation_summary_flag,
  output logic              overcurrent_trip,
  output logic              overvoltage_trip,
  output logic              unregulated_flag,
  output logic              holdoff_active,
  output ques_regs_t        ques_regs
);

  localparam int UNIT_CYCLES = `CYCLES_PER_UNIT;
  localparam int DIV_W       = $clog2(UNIT_CYCLES + 1);

  initial
  begin
    if (UNIT_CYCLES < 1) $error("holdoff unit shorter than one clock");
  end

  // Write value legal for filters and masks
  function automatic logic value_ok(input logic [`REG_W-1:0] v);
    value_ok = (v <= `FILTER_MAX);
  endfunction : value_ok

  // Reset release through two flip-flops
  logic rst_meta_r;  // First stage
  logic rst_n;       // Released reset for the rest of the design

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Pin synchronisers
  logic       cal_busy;     // Calibration in progress
  reg_flags_t live_flags;   // Live regulation state
  logic       ovp_level;    // Overvoltage sensed

  pin_sync #(.W(1)) u_cal_sync (
    .clock     (clock),
    .rst_n     (rst_n),
    .pin_in    (cal_busy_pin),
    .level_out (cal_busy)
  );

  pin_sync #(.W(4)) u_reg_sync (
    .clock     (clock),
    .rst_n     (rst_n),
    .pin_in    ({overvoltage_pin, regulation_pins}),
    .level_out ({ovp_level, live_flags})
  );

  // Holdoff unit divider
  logic [DIV_W-1:0] div_r;    // Cycle count within a unit
  logic [DIV_W-1:0] div_nxt;
  logic             unit_tick;

  always_comb
  begin
    unit_tick = (div_r == DIV_W'(UNIT_CYCLES - 1));
    div_nxt   = unit_tick ? '0 : div_r + DIV_W'(1);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) div_r <= '0;
    else        div_r <= div_nxt;
  end

  // Regulation flags pass the holdoff before being recorded
  reg_flags_t         rec_flags;   // Recorded regulation state
  logic [`REG_W-1:0]  delay_r;     // Programmed holdoff in units

  holdoff_timer #(.CW(`REG_W)) u_holdoff (
    .clock          (clock),
    .rst_n          (rst_n),
    .unit_tick      (unit_tick),
    .reprogram      (output_reprogram),
    .delay_units    (delay_r),
    .live_flags     (live_flags),
    .recorded_flags (rec_flags),
    .holding        (holdoff_active)
  );

  // Trigger wait flag
  logic wait_r;    // Waiting for trigger
  logic wait_nxt;
  logic rearm_r;   // Continuous re-arm one cycle after a trigger
  logic rearm_nxt;

  always_comb
  begin
    wait_nxt  = wait_r;
    rearm_nxt = 1'b0;
    if (trigger_accept && wait_r)
    begin
      wait_nxt  = 1'b0;
      rearm_nxt = trigger_continuous;
    end
    else if (trigger_initiate || rearm_r)
    begin
      wait_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_r  <= 1'b0;
      rearm_r <= 1'b0;
    end
    else
    begin
      wait_r  <= wait_nxt;
      rearm_r <= rearm_nxt;
    end
  end

  // Live condition word, unused bits zero
  logic [`REG_W-1:0] cond;

  always_comb
  begin
    cond                 = `REG_ZERO;
    cond[`OPERATION_SUMMARY_FLAG_CAL_BIT]  = cal_busy;
    cond[`OPERATION_SUMMARY_FLAG_WAIT_BIT] = wait_r;
    cond[`OPERATION_SUMMARY_FLAG_VOLT_BIT] = rec_flags.voltage_regulation_flag;
    cond[`OPERATION_SUMMARY_FLAG_CURR_BIT] = rec_flags.current_regulation_flag;
  end

  // Register file state
  logic [`REG_W-1:0] cond_prev_r;   // Condition one cycle ago
  logic [`REG_W-1:0] event_r;       // Latched events
  logic [`REG_W-1:0] mask_r;        // Summary mask
  logic [`REG_W-1:0] fall_r;        // Falling edge filter
  logic [`REG_W-1:0] rise_r;        // Rising edge filter
  logic [`REG_W-1:0] qrise_r;       // Questionable rising filter
  logic [`REG_W-1:0] qfall_r;       // Questionable falling filter
  logic [`REG_W-1:0] qmask_r;       // Questionable summary mask
  logic [`REG_W-1:0] event_nxt;
  logic [`REG_W-1:0] mask_nxt;
  logic [`REG_W-1:0] fall_nxt;
  logic [`REG_W-1:0] rise_nxt;
  logic [`REG_W-1:0] qrise_nxt;
  logic [`REG_W-1:0] qfall_nxt;
  logic [`REG_W-1:0] qmask_nxt;
  logic [`REG_W-1:0] delay_nxt;
  logic [`REG_W-1:0] edge_set;      // Filtered transitions this cycle
  logic [`REG_W-1:0] write_set;     // Events raised by filter writes
  logic              summary_nxt;
  logic              rsp_valid_nxt;
  rsp_t              rsp_r;
  rsp_t              rsp_nxt;
  logic              is_write;
  logic              is_read;

  // Command decode, edge detection and next register values
  always_comb
  begin
    is_write  = cmd_valid && (cmd.op == OP_WRITE);
    is_read   = cmd_valid && (cmd.op == OP_READ);
    mask_nxt  = mask_r;
    fall_nxt  = fall_r;
    rise_nxt  = rise_r;
    qrise_nxt = qrise_r;
    qfall_nxt = qfall_r;
    qmask_nxt = qmask_r;
    delay_nxt = delay_r;
    write_set = `REG_ZERO;
    rsp_nxt   = '{data: `REG_ZERO, error: 1'b0};
    // Edges against the registered copy, both filters per bit
    edge_set  = (cond & ~cond_prev_r & rise_r)
              | (~cond & cond_prev_r & fall_r);
    // Preset request
    if (cmd_valid && (cmd.op == OP_PRESET))
    begin
      rise_nxt  = `OPERATION_SUMMARY_FLAG_RISE_PRESET;
      qrise_nxt = `QUES_RISE_PRESET;
      fall_nxt  = `REG_ZERO;
      qfall_nxt = `REG_ZERO;
      mask_nxt  = `REG_ZERO;
      qmask_nxt = `REG_ZERO;
    end
    // Holdoff delay write
    else if (cmd_valid && (cmd.op == OP_DELAY))
    begin
      delay_nxt = cmd.data;
    end
    // Register write, range checked
    else if (is_write)
    begin
      if (!value_ok(cmd.data) || (cmd.sel == REG_COND) || (cmd.sel == REG_EVENT))
      begin
        rsp_nxt.error = 1'b1;
      end
      else
      begin
        unique case (cmd.sel)
          REG_MASK:  mask_nxt = cmd.data;
          REG_FALL:
          begin
            fall_nxt  = cmd.data;
            write_set = cmd.data & ~fall_r & ~cond;
          end
          REG_RISE:
          begin
            rise_nxt  = cmd.data;
            write_set = cmd.data & ~rise_r & cond;
          end
          REG_QRISE: qrise_nxt = cmd.data;
          REG_QFALL: qfall_nxt = cmd.data;
          REG_QMASK: qmask_nxt = cmd.data;
          default:   rsp_nxt.error = 1'b1;
        endcase
      end
    end
    // Register read
    else if (is_read)
    begin
      unique case (cmd.sel)
        REG_COND:  rsp_nxt.data = cond;
        REG_EVENT: rsp_nxt.data = event_r;
        REG_MASK:  rsp_nxt.data = mask_r;
        REG_FALL:  rsp_nxt.data = fall_r;
        REG_RISE:  rsp_nxt.data = rise_r;
        REG_QRISE: rsp_nxt.data = qrise_r;
        REG_QFALL: rsp_nxt.data = qfall_r;
        REG_QMASK: rsp_nxt.data = qmask_r;
        default:   rsp_nxt.error = 1'b1;
      endcase
    end
    // Event clear on read, new events win over the clear
    if (is_read && (cmd.sel == REG_EVENT))
    begin
      event_nxt = edge_set | write_set;
    end
    else
    begin
      event_nxt = event_r | edge_set | write_set;
    end
    summary_nxt   = |(event_nxt & mask_nxt);
    rsp_valid_nxt = cmd_valid;
  end

  // Register file flip-flops
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cond_prev_r <= `REG_ZERO;
      event_r     <= `REG_ZERO;
      mask_r      <= `REG_ZERO;
      fall_r      <= `REG_ZERO;
      rise_r      <= `REG_ZERO;
      qrise_r     <= `REG_ZERO;
      qfall_r     <= `REG_ZERO;
      qmask_r     <= `REG_ZERO;
      delay_r     <= HOLDOFF_DEFAULT;
      rsp_r       <= '0;
      rsp_valid   <= 1'b0;
      operation_summary_flag <= 1'b0;
    end
    else
    begin
      cond_prev_r <= cond;
      event_r     <= event_nxt;
      mask_r      <= mask_nxt;
      fall_r      <= fall_nxt;
      rise_r      <= rise_nxt;
      qrise_r     <= qrise_nxt;
      qfall_r     <= qfall_nxt;
      qmask_r     <= qmask_nxt;
      delay_r     <= delay_nxt;
      rsp_r       <= rsp_nxt;
      rsp_valid   <= rsp_valid_nxt;
      operation_summary_flag <= summary_nxt;
    end
  end

  // Protection outputs
  logic ocp_nxt;
  logic ocp_r;
  logic ovp_r;

  always_comb
  begin
    ocp_nxt = overcurrent_enable && rec_flags.current_regulation_flag;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ocp_r            <= 1'b0;
      ovp_r            <= 1'b0;
      unregulated_flag <= 1'b0;
    end
    else
    begin
      ocp_r            <= ocp_nxt;
      ovp_r            <= ovp_level;
      unregulated_flag <= rec_flags.unregulated_flag;
    end
  end

  assign overcurrent_trip = ocp_r;
  assign overvoltage_trip = ovp_r;
  assign rsp              = rsp_r;
  assign ques_regs        = '{questionable_rising_filter:  qrise_r,
                              questionable_falling_filter: qfall_r,
                              questionable_summary_mask:   qmask_r};

endmodule : operation_status_register_group

// ==== rtl/status_params.svh ====
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH

// Register width and value limits
`define REG_W              16
`define REG_ZERO           16'h0000
`define FILTER_MAX         16'h7fd7
`define OPERATION_SUMMARY_FLAG_DEFINED       16'h0521
`define OPERATION_SUMMARY_FLAG_RISE_PRESET   16'h0521
`define QUES_RISE_PRESET   16'h0613

// Operation condition bit positions
`define OPERATION_SUMMARY_FLAG_CAL_BIT       0
`define OPERATION_SUMMARY_FLAG_WAIT_BIT      5
`define OPERATION_SUMMARY_FLAG_VOLT_BIT      8
`define OPERATION_SUMMARY_FLAG_CURR_BIT      10

// Register selects on the command port
`define SEL_W              3
`define SEL_COND           3'h0
`define SEL_EVENT          3'h1
`define SEL_MASK           3'h2
`define SEL_FALL           3'h3
`define SEL_RISE           3'h4
`define SEL_QRISE          3'h5
`define SEL_QFALL          3'h6
`define SEL_QMASK          3'h7

// Timing: clock period and holdoff unit in ns
`define CLK_PERIOD_NS      8
`define HOLDOFF_UNIT_NS    1000
`define CYCLES_PER_UNIT    ((`HOLDOFF_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLDOFF_DEFAULT    16'h0014

`endif

// ==== rtl/status_pkg.sv ====
`include "status_params.svh"

package status_pkg;

  // Command operations
  typedef enum logic [1:0] {
    OP_READ   = 2'h0,
    OP_WRITE  = 2'h1,
    OP_PRESET = 2'h2,
    OP_DELAY  = 2'h3
  } cmd_op_t;

  // Register selects
  typedef enum logic [`SEL_W-1:0] {
    REG_COND  = `SEL_COND,
    REG_EVENT = `SEL_EVENT,
    REG_MASK  = `SEL_MASK,
    REG_FALL  = `SEL_FALL,
    REG_RISE  = `SEL_RISE,
    REG_QRISE = `SEL_QRISE,
    REG_QFALL = `SEL_QFALL,
    REG_QMASK = `SEL_QMASK
  } reg_sel_t;

  // Command word
  typedef struct packed {
    cmd_op_t             op;
    reg_sel_t            sel;
    logic [`REG_W-1:0]   data;
  } cmd_t;

  // Response word
  typedef struct packed {
    logic [`REG_W-1:0]   data;
    logic                error;
  } rsp_t;

  // Regulation flags, live or recorded
  typedef struct packed {
    logic unregulated_flag;
    logic current_regulation_flag;
    logic voltage_regulation_flag;
  } reg_flags_t;

  // Questionable filter and mask values handed to that group
  typedef struct packed {
    logic [`REG_W-1:0]   questionable_rising_filter;
    logic [`REG_W-1:0]   questionable_falling_filter;
    logic [`REG_W-1:0]   questionable_summary_mask;
  } ques_regs_t;

endpackage : status_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps

// Three-stage synchroniser; value taken once stages two and three agree
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  initial
  begin
    if (W < 1) $error("pin_sync: width must be at least one");
  end

  logic [W-1:0] meta_r;    // First stage, read only by second
  logic [W-1:0] s2_r;      // Second stage
  logic [W-1:0] s3_r;      // Third stage
  logic [W-1:0] level_r;   // Accepted level
  logic [W-1:0] level_nxt; // Next accepted level

  // Accept per bit when stages agree
  always_comb
  begin
    level_nxt = level_r;
    for (int i = 0; i < W; i++)
    begin
      if (s2_r[i] == s3_r[i]) level_nxt[i] = s3_r[i];
    end
  end

  // Stage registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r  <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      level_r <= '0;
    end
    else
    begin
      meta_r  <= pin_in;
      s2_r    <= meta_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;

endmodule : pin_sync

// ==== rtl/holdoff_timer.sv ====
`timescale 1ns/10ps

// Holds the recorded regulation flags for a programmed time after reprogramming
module holdoff_timer
  import status_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          unit_tick,
  input  wire logic          reprogram,
  input  wire logic [CW-1:0] delay_units,
  input  wire reg_flags_t    live_flags,
  output reg_flags_t         recorded_flags,
  output logic               holding
);

  initial
  begin
    if (CW < 1) $error("holdoff_timer: counter width must be at least one");
  end

  logic [CW-1:0] count_r;     // Units still to wait
  logic [CW-1:0] count_nxt;
  reg_flags_t    record_r;    // Flags seen by the condition register
  reg_flags_t    record_nxt;

  // Countdown and record update
  always_comb
  begin
    count_nxt  = count_r;
    record_nxt = record_r;
    if (reprogram)
    begin
      count_nxt = delay_units;                // Restart on every reprogramming
    end
    else if (count_r != '0)
    begin
      if (unit_tick) count_nxt = count_r - CW'(1);
    end
    else
    begin
      record_nxt = live_flags;                // Delay spent: follow live state
    end
  end

  // Timer registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r  <= '0;
      record_r <= '0;
    end
    else
    begin
      count_r  <= count_nxt;
      record_r <= record_nxt;
    end
  end

  assign recorded_flags = record_r;
  assign holding        = (count_r != '0);

endmodule : holdoff_timer

// ==== tb/status_group_chk.sv ====
`timescale 1ns/10ps
`include "status_params.svh"

// Port-level checks of the operation status register group
module status_group_chk
  import status_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  input wire logic rsp_valid,
  input wire rsp_t rsp,
  input wire logic overvoltage_pin,
  input wire logic overcurrent_enable,
  input wire logic operation_summary_flag,
  input wire logic overcurrent_trip,
  input wire logic overvoltage_trip,
  input wire logic unregulated_flag,
  input wire logic holdoff_active
);
  logic last_v_r;   // Command taken at last edge
  cmd_t last_cmd_r; // The command now being answered

  // Remember which command the response belongs to
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      last_v_r   <= 1'b0;
      last_cmd_r <= '0;
    end
    else
    begin
      last_v_r   <= cmd_valid;
      last_cmd_r <= cmd;
    end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  chk_rsp_timing: assert property (rsp_valid == last_v_r)
    else $error("response not one cycle after command");
  chk_read_ok: assert property (rsp_valid && last_cmd_r.op == OP_READ |-> !rsp.error)
    else $error("read refused");
  chk_cond_ro: assert property (rsp_valid && last_cmd_r.op == OP_WRITE
    && last_cmd_r.sel inside {REG_COND, REG_EVENT} |-> rsp.error) else $error("read-only write taken");
  chk_range_cut: assert property (rsp_valid && last_cmd_r.op == OP_WRITE
    && last_cmd_r.data > `FILTER_MAX |-> rsp.error) else $error("value above range taken");
  chk_range_ok: assert property (rsp_valid && last_cmd_r.op == OP_WRITE && last_cmd_r.data <= `FILTER_MAX
    && last_cmd_r.sel inside {REG_MASK, REG_FALL, REG_RISE} |-> !rsp.error) else $error("legal write refused");
  chk_cond_unused: assert property (rsp_valid && last_cmd_r.op == OP_READ && last_cmd_r.sel == REG_COND
    |-> (rsp.data & ~`OPERATION_SUMMARY_FLAG_DEFINED) == 16'h0) else $error("unused condition bit set");
  chk_mask_zero: assert property (cmd_valid && cmd.op == OP_WRITE && cmd.sel == REG_MASK
    && cmd.data == 16'h0 |=> !operation_summary_flag) else $error("summary with empty mask");
  chk_preset_mask: assert property (cmd_valid && cmd.op == OP_PRESET |=> !operation_summary_flag)
    else $error("summary after preset");
  chk_ovp_fast: assert property ($rose(overvoltage_pin) |-> ##[1:8] overvoltage_trip)
    else $error("overvoltage trip late");
  chk_trip_off: assert property (!$past(overcurrent_enable) |-> !overcurrent_trip)
    else $error("overcurrent trip while disabled");
  chk_hold_frozen: assert property (holdoff_active && $past(holdoff_active) && $past(holdoff_active, 2)
    && $past(overcurrent_enable) == $past(overcurrent_enable, 2)
    |-> $stable(overcurrent_trip) && $stable(unregulated_flag)) else $error("flags moved in holdoff");
endmodule : status_group_chk

bind operation_status_register_group status_group_chk i_chk (.clock, .arst_n, .cmd_valid, .cmd,
  .rsp_valid, .rsp, .overvoltage_pin, .overcurrent_enable, .operation_summary_flag, .overcurrent_trip,
  .overvoltage_trip, .unregulated_flag, .holdoff_active);

// ==== tb/remote_host.sv ====
`timescale 1ns/10ps

// Remote programming host: one command at a time
module remote_host
  import status_pkg::*;
(
  input  wire logic clock,
  output logic      cmd_valid,
  output cmd_t      cmd,
  input  wire logic rsp_valid,
  input  wire rsp_t rsp
);
  // Port idle until the first command
  initial
  begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // Drive after an edge, take the answer one edge later
  task automatic xfer(input cmd_op_t op, input reg_sel_t sel, input logic [15:0] d,
                      output rsp_t r, output logic ok);
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd       = '{op: op, sel: sel, data: d};
    @(posedge clock);
    #1;
    ok        = rsp_valid;
    r         = rsp;
    cmd_valid = 1'b0;
    cmd       = ~cmd; // Stale word never looks valid
  endtask : xfer
endmodule : remote_host

// ==== tb/test_operation_status_register_group.sv ====
`timescale 1ns/10ps
`include "status_params.svh"

// Self-checking bench for the operation status register group
module test_operation_status_register_group
  import status_pkg::*;
;
  logic       clock;
  logic       arst_n;
  logic       cmd_valid;
  cmd_t       cmd;
  logic       rsp_valid;
  rsp_t       rsp;
  logic       cal_busy_pin;          // Power module pins
  reg_flags_t regulation_pins;
  logic       overvoltage_pin;
  logic       overcurrent_enable;
  logic       output_reprogram;      // Strobes
  logic       trigger_initiate;
  logic       trigger_accept;
  logic       trigger_continuous;
  logic       operation_summary_flag;
  logic       overcurrent_trip;
  logic       overvoltage_trip;
  logic       unregulated_flag;
  logic       holdoff_active;
  ques_regs_t ques_regs;             // Questionable values handed on
  int         n_fail    = 0;         // Mismatches
  int         tests_run = 0;         // Comparisons
  int         ncyc      = 0;         // Cycles for the timeout

  operation_status_register_group i_dut (.clock, .arst_n, .cmd_valid, .cmd, .rsp_valid, .rsp,
    .cal_busy_pin, .regulation_pins, .overvoltage_pin, .overcurrent_enable, .output_reprogram,
    .trigger_initiate, .trigger_accept, .trigger_continuous, .operation_summary_flag,
    .overcurrent_trip, .overvoltage_trip, .unregulated_flag, .holdoff_active, .ques_regs);
  remote_host i_host (.clock, .cmd_valid, .cmd, .rsp_valid, .rsp);

  // 125 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock)
  begin
    ncyc = ncyc + 1;
    if (ncyc == 20000)
    begin
      n_fail = n_fail + 1;
      test_done();
    end
  end

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic test_done();
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // Condition word from the live flags
  function automatic logic [15:0] cw(input logic cal, input logic wt, input logic v, input logic c);
    cw = 16'h0;
    cw[`OPERATION_SUMMARY_FLAG_CAL_BIT]  = cal;
    cw[`OPERATION_SUMMARY_FLAG_WAIT_BIT] = wt;
    cw[`OPERATION_SUMMARY_FLAG_VOLT_BIT] = v;
    cw[`OPERATION_SUMMARY_FLAG_CURR_BIT] = c;
  endfunction : cw

  // Events caught by the filters between two condition words
  function automatic logic [15:0] ev(input logic [15:0] o, input logic [15:0] n,
                                     input logic [15:0] ri, input logic [15:0] fa);
    ev = (~o & n & ri) | (o & ~n & fa);
  endfunction : ev

  // Read and compare; valid, no error, data
  task automatic rd(input reg_sel_t s, input logic [15:0] exp);
    rsp_t r;
    logic ok;
    i_host.xfer(OP_READ, s, 16'h0, r, ok);
    check({ok, r.error, r.data}, {2'b10, exp});
  endtask : rd

  // Any non-read command, error flag compared
  task automatic put(input cmd_op_t o, input reg_sel_t s, input logic [15:0] d, input logic e);
    rsp_t r;
    logic ok;
    i_host.xfer(o, s, d, r, ok);
    check({16'h0, ok, r.error}, {16'h0, 1'b1, e});
  endtask : put

  task automatic pulse(ref logic p);
    p = 1'b1;
    cyc(1);
    p = 1'b0;
  endtask : pulse

  initial
  begin
    rsp_t       r;
    logic       ok;
    logic [15:0] d;
    reg_sel_t   s;
    void'($urandom(9));
    arst_n             = 1'b0;
    cal_busy_pin       = 1'b0;
    regulation_pins    = '0;
    overvoltage_pin    = 1'b0;
    overcurrent_enable = 1'b0;
    output_reprogram   = 1'b0;
    trigger_initiate   = 1'b0;
    trigger_accept     = 1'b0;
    trigger_continuous = 1'b0;
    cyc(12);
    arst_n = 1'b1;
    cyc(4);
    // Defaults, read-only places, range edges
    for (int i = 2; i < 8; i++)
      rd(reg_sel_t'(i), 16'h0);
    rd(REG_COND, 16'h0);
    put(OP_WRITE, REG_COND, 16'h0001, 1'b1);
    put(OP_WRITE, REG_EVENT, 16'h0001, 1'b1);
    put(OP_WRITE, REG_MASK, `FILTER_MAX, 1'b0);
    rd(REG_MASK, `FILTER_MAX);
    // Random legal and refused values
    repeat (24)
    begin
      s = reg_sel_t'(3'(2 + $urandom_range(5)));
      d = 16'($urandom_range(32727));
      put(OP_WRITE, s, d, 1'b0);
      put(OP_WRITE, s, 16'(32728 + $urandom_range(32807)), 1'b1);
      rd(s, d);
    end
    i_host.xfer(OP_READ, REG_EVENT, 16'h0, r, ok);
    rd(REG_EVENT, 16'h0);
    // Preset values
    put(OP_PRESET, REG_COND, 16'h0, 1'b0);
    rd(REG_RISE, 16'h0521);
    rd(REG_QRISE, 16'h0613);
    check(18'(ques_regs.questionable_rising_filter), 18'h0613);
    check(18'(ques_regs.questionable_falling_filter | ques_regs.questionable_summary_mask), 18'h0);
    for (int i = 2; i < 8; i++)
      if (i != 4 && i != 5)
        rd(reg_sel_t'(i), 16'h0);
    put(OP_DELAY, REG_COND, 16'h0, 1'b0);
    // All four flags rise
    cal_busy_pin    = 1'b1;
    regulation_pins = 3'b011;
    pulse(trigger_initiate);
    cyc(10);
    rd(REG_COND, cw(1, 1, 1, 1));
    rd(REG_EVENT, ev(16'h0, cw(1, 1, 1, 1), 16'h0521, 16'h0));
    rd(REG_EVENT, 16'h0);
    // Falling filter on one bit, none on another
    put(OP_WRITE, REG_RISE, 16'h0, 1'b0);
    put(OP_WRITE, REG_FALL, 16'h0001, 1'b0);
    cal_busy_pin    = 1'b0;
    regulation_pins = 3'b010;
    cyc(10);
    rd(REG_EVENT, ev(cw(1, 1, 1, 1), cw(0, 1, 0, 1), 16'h0, 16'h0001));
    // Filter writes raise events on the present state
    put(OP_WRITE, REG_RISE, 16'h0400, 1'b0);
    rd(REG_EVENT, 16'h0400 & cw(0, 1, 0, 1));
    put(OP_WRITE, REG_FALL, 16'h0101, 1'b0);
    rd(REG_EVENT, 16'h0100 & ~cw(0, 1, 0, 1));
    // Both filters: either direction counts
    put(OP_WRITE, REG_FALL, 16'h0400, 1'b0);
    regulation_pins = 3'b000;
    cyc(10);
    rd(REG_EVENT, ev(cw(0, 1, 0, 1), cw(0, 1, 0, 0), 16'h0400, 16'h0400));
    regulation_pins = 3'b010;
    cyc(10);
    rd(REG_EVENT, ev(cw(0, 1, 0, 0), cw(0, 1, 0, 1), 16'h0400, 16'h0400));
    // Summary flag follows masked events
    put(OP_WRITE, REG_RISE, 16'h0020, 1'b0);
    check(18'(operation_summary_flag), 18'h0);
    put(OP_WRITE, REG_MASK, 16'h0020, 1'b0);
    cyc(2);
    check(18'(operation_summary_flag), 18'h1);
    rd(REG_EVENT, 16'h0020);
    cyc(2);
    check(18'(operation_summary_flag), 18'h0);
    // Trigger taken, then continuous re-arm
    pulse(trigger_accept);
    cyc(6);
    rd(REG_COND, cw(0, 0, 0, 1));
    trigger_continuous = 1'b1;
    pulse(trigger_initiate);
    cyc(3);
    check(18'(operation_summary_flag), 18'h1);
    pulse(trigger_accept);
    cyc(6);
    rd(REG_COND, cw(0, 1, 0, 1));
    trigger_continuous = 1'b0;
    rd(REG_EVENT, 16'h0020);
    // Holdoff after reprogramming
    overcurrent_enable = 1'b1;
    cyc(4);
    check(18'(overcurrent_trip), 18'h1);
    put(OP_DELAY, REG_COND, 16'h0002, 1'b0);
    regulation_pins = 3'b100;
    pulse(output_reprogram);
    cyc(30);
    check(18'({overcurrent_trip, unregulated_flag, holdoff_active}), 18'h5);
    rd(REG_COND, cw(0, 1, 0, 1));
    overvoltage_pin = 1'b1;
    cyc(8);
    check(18'(overvoltage_trip), 18'h1);
    cyc(300);
    check(18'({overcurrent_trip, unregulated_flag, holdoff_active}), 18'h2);
    rd(REG_COND, cw(0, 1, 0, 0));
    put(OP_WRITE, REG_MASK, 16'h0, 1'b0);
    test_done();
  end
endmodule : test_operation_status_register_group
